// ===== rtl/sfcu_pkg.sv
// sfcu_pkg: constants and word layouts of the serial flow control unit.
// assumes one 20 MHz clock and software commands delivered as 32-bit words.
`default_nettype none
package sfcu_pkg;
  localparam logic [7:0] SUB_OUT_FLOW = 8'h23;
  localparam logic [7:0] SUB_IN_FLOW = 8'h22;
  localparam logic [7:0] SUB_CTS_EVENT = 8'h1a;
  localparam logic [7:0] SUB_STATUS = 8'h1c;
  localparam int DCD_REQ_BIT = 10;
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_MANUAL = 3'h1;
  localparam logic [2:0] MODE_AUTO_CTS = 3'h2;
  localparam logic [2:0] MODE_AUTO_RTS = 3'h3;
  localparam logic [2:0] MODE_FULL_AUTO = 3'h4;
  localparam logic [2:0] MODE_DYNAMIC = 3'h5;
  localparam logic [2:0] MODE_RESET = MODE_NONE;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [15:0] TX_DEPTH = 16'h0100;
  localparam logic [4:0] CHUNK_FIXED = 5'h10;
  localparam logic [2:0] BAUD_19200 = 3'h4;

  // output flow word layout
  typedef struct packed {
    logic [7:0] rts_ext;
    logic [9:0] rsv;
    logic wr_block;
    logic chunk_fixed;
    logic no_demand;
    logic [2:0] mode;
    logic [7:0] subcode;
  } sfcu_out_flow_t;

  // cts event word layout
  typedef struct packed {
    logic [15:0] event_num;
    logic [2:0] rsv_hi;
    logic on_negate;
    logic on_assert;
    logic [2:0] rsv_lo;
    logic [7:0] subcode;
  } sfcu_cts_event_t;

  // status word layout
  typedef struct packed {
    logic [15:0] tx_free;
    logic [4:0] rsv_hi;
    logic [2:0] mode;
    logic rsv7;
    logic overrun;
    logic framing;
    logic parity;
    logic [1:0] rsv_lo;
    logic dcd;
    logic cts;
  } sfcu_status_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_EXT = 3'b100
  } sfcu_rts_state_t;
endpackage
`default_nettype wire

// ===== rtl/sfcu_core.sv
// sfcu_core: rts/cts flow control, dcd gating, cts events and status word.
// assumes all inputs synchronous to i_mclk; transmitter reports sent chars.
`timescale 1ns/1ps
`default_nettype none
module sfcu_core (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [31:0] i_cmd_word,
  input wire logic i_stat_req,
  input wire logic i_rts_cmd_valid,
  input wire logic i_rts_cmd_level,
  input wire logic i_wr_valid,
  input wire logic i_char_sent,
  input wire logic i_char_tick,
  input wire logic i_cts,
  input wire logic i_dcd,
  input wire logic i_rx_near_full,
  input wire logic i_rx_drained,
  input wire logic [2:0] i_baud_code,
  input wire logic i_err_overrun,
  input wire logic i_err_framing,
  input wire logic i_err_parity,
  output logic o_rts,
  output logic o_tx_enable,
  output logic o_tx_demand,
  output logic o_wr_ack,
  output logic o_wr_error,
  output logic o_wr_wait,
  output logic o_rx_accept,
  output logic [4:0] o_rx_chunk_len,
  output logic o_stat_valid,
  output logic [31:0] o_stat_word,
  output logic o_event_valid,
  output logic [15:0] o_event_num
);
  function automatic logic [4:0] chunk_for(input logic [2:0] baud, input logic fixed);
    if (fixed || baud >= sfcu_pkg::BAUD_19200) begin
      return sfcu_pkg::CHUNK_FIXED;
    end
    return 5'(5'h01 << baud);
  endfunction

  function automatic logic is_auto(input logic [2:0] m);
    return m == sfcu_pkg::MODE_NONE || m == sfcu_pkg::MODE_AUTO_RTS ||
      m == sfcu_pkg::MODE_FULL_AUTO;
  endfunction

  function automatic logic needs_cts(input logic [2:0] m);
    return m == sfcu_pkg::MODE_AUTO_CTS || m == sfcu_pkg::MODE_FULL_AUTO ||
      m == sfcu_pkg::MODE_DYNAMIC;
  endfunction

  sfcu_pkg::sfcu_out_flow_t cmd_out;
  sfcu_pkg::sfcu_cts_event_t cmd_evt;
  assign cmd_out = i_cmd_word;
  assign cmd_evt = i_cmd_word;

  // configuration group
  logic [2:0] mode_q, mode_d;
  logic [7:0] ext_q, ext_d;
  logic wr_block_q, wr_block_d, fixed_q, fixed_d, no_dem_q, no_dem_d;
  logic dcd_req_q, dcd_req_d, sw_rts_q, sw_rts_d;

  always_comb begin
    mode_d = mode_q;
    ext_d = ext_q;
    wr_block_d = wr_block_q;
    fixed_d = fixed_q;
    no_dem_d = no_dem_q;
    dcd_req_d = dcd_req_q;
    sw_rts_d = sw_rts_q;
    if (i_cmd_valid && cmd_out.subcode == sfcu_pkg::SUB_OUT_FLOW) begin
      ext_d = cmd_out.rts_ext;
      wr_block_d = cmd_out.wr_block;
      fixed_d = cmd_out.chunk_fixed;
      no_dem_d = cmd_out.no_demand;
      if (cmd_out.mode <= sfcu_pkg::MODE_DYNAMIC) begin
        mode_d = cmd_out.mode;
      end
    end
    if (i_cmd_valid && cmd_out.subcode == sfcu_pkg::SUB_IN_FLOW) begin
      dcd_req_d = i_cmd_word[sfcu_pkg::DCD_REQ_BIT];
    end
    if (i_rts_cmd_valid) begin
      sw_rts_d = i_rts_cmd_level;
      if (mode_q == sfcu_pkg::MODE_NONE) begin
        mode_d = sfcu_pkg::MODE_MANUAL;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mode_q <= sfcu_pkg::MODE_RESET;
      ext_q <= sfcu_pkg::EXT_RESET;
      wr_block_q <= 1'b0;
      fixed_q <= 1'b0;
      no_dem_q <= 1'b0;
      dcd_req_q <= 1'b0;
      sw_rts_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ext_q <= ext_d;
      wr_block_q <= wr_block_d;
      fixed_q <= fixed_d;
      no_dem_q <= no_dem_d;
      dcd_req_q <= dcd_req_d;
      sw_rts_q <= sw_rts_d;
    end
  end

  // transmit buffer occupancy and rts sequencing
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] ext_cnt_q, ext_cnt_d;
  sfcu_pkg::sfcu_rts_state_t st_q, st_d;
  logic pend_q, pend_d, wr_take, sent, full;
  logic rx_room_q, rx_room_d, rts_d, txen_d, dem_d, ack_d, err_d;

  assign full = cnt_q == sfcu_pkg::TX_DEPTH;
  assign sent = i_char_sent && cnt_q != 16'h0000;

  always_comb begin
    wr_take = 1'b0;
    pend_d = pend_q;
    err_d = 1'b0;
    if (pend_q) begin
      if (!full) begin
        wr_take = 1'b1;
        pend_d = 1'b0;
      end
    end else if (i_wr_valid) begin
      if (!full) begin
        wr_take = 1'b1;
      end else if (wr_block_q && needs_cts(mode_q)) begin
        pend_d = 1'b1;
      end else begin
        err_d = 1'b1;
      end
    end
    ack_d = wr_take;
    cnt_d = 16'(cnt_q + {15'h0000, wr_take} - {15'h0000, sent});
    dem_d = wr_take && cnt_q == 16'h0000 && !no_dem_q;
  end

  always_comb begin
    st_d = st_q;
    ext_cnt_d = ext_cnt_q;
    unique case (st_q)
      sfcu_pkg::ST_IDLE: begin
        if (wr_take && is_auto(mode_q)) begin
          st_d = sfcu_pkg::ST_SEND;
        end
      end
      sfcu_pkg::ST_SEND: begin
        if (cnt_q == 16'h0000 && !wr_take) begin
          if (mode_q != sfcu_pkg::MODE_NONE && ext_q != 8'h00) begin
            st_d = sfcu_pkg::ST_EXT;
            ext_cnt_d = ext_q;
          end else begin
            st_d = sfcu_pkg::ST_IDLE;
          end
        end
      end
      sfcu_pkg::ST_EXT: begin
        if (wr_take) begin
          st_d = sfcu_pkg::ST_SEND;
        end else if (i_char_tick) begin
          ext_cnt_d = 8'(ext_cnt_q - 8'h01);
          if (ext_cnt_q == 8'h01) begin
            st_d = sfcu_pkg::ST_IDLE;
          end
        end
      end
    endcase
    if (!is_auto(mode_q)) begin
      st_d = sfcu_pkg::ST_IDLE;
    end
  end

  always_comb begin
    rx_room_d = rx_room_q;
    if (i_rx_near_full) begin
      rx_room_d = 1'b0;
    end else if (i_rx_drained) begin
      rx_room_d = 1'b1;
    end
    unique case (mode_q)
      sfcu_pkg::MODE_NONE: rts_d = st_d != sfcu_pkg::ST_IDLE;
      sfcu_pkg::MODE_AUTO_RTS, sfcu_pkg::MODE_FULL_AUTO:
        rts_d = sw_rts_d || st_d != sfcu_pkg::ST_IDLE;
      sfcu_pkg::MODE_DYNAMIC: rts_d = rx_room_d;
      default: rts_d = sw_rts_d;
    endcase
    txen_d = cnt_d != 16'h0000 && (!needs_cts(mode_q) || i_cts);
    if (mode_q == sfcu_pkg::MODE_FULL_AUTO && !o_rts) begin
      txen_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cnt_q <= 16'h0000;
      ext_cnt_q <= 8'h00;
      st_q <= sfcu_pkg::ST_IDLE;
      pend_q <= 1'b0;
      rx_room_q <= 1'b1;
      o_rts <= 1'b0;
      o_tx_enable <= 1'b0;
      o_tx_demand <= 1'b0;
      o_wr_ack <= 1'b0;
      o_wr_error <= 1'b0;
      o_wr_wait <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ext_cnt_q <= ext_cnt_d;
      st_q <= st_d;
      pend_q <= pend_d;
      rx_room_q <= rx_room_d;
      o_rts <= rts_d;
      o_tx_enable <= txen_d;
      o_tx_demand <= dem_d;
      o_wr_ack <= ack_d;
      o_wr_error <= err_d;
      o_wr_wait <= pend_d;
    end
  end

  // receive side, status and cts events
  logic ovr_q, ovr_d, frm_q, frm_d, par_q, par_d, cts_p_q;
  logic arm_q, arm_d, on_as_q, on_as_d, on_ng_q, on_ng_d, fire;
  logic [15:0] evn_q, evn_d;
  sfcu_pkg::sfcu_status_t stat;

  always_comb begin
    // set wins over the read clear
    ovr_d = i_err_overrun || (ovr_q && !i_stat_req);
    frm_d = i_err_framing || (frm_q && !i_stat_req);
    par_d = i_err_parity || (par_q && !i_stat_req);
    stat = '0;
    stat.tx_free = 16'(sfcu_pkg::TX_DEPTH - cnt_q);
    stat.mode = mode_q;
    stat.overrun = ovr_q;
    stat.framing = frm_q;
    stat.parity = par_q;
    stat.dcd = i_dcd;
    stat.cts = i_cts;
    arm_d = arm_q;
    on_as_d = on_as_q;
    on_ng_d = on_ng_q;
    evn_d = evn_q;
    fire = arm_q && ((on_as_q && i_cts && !cts_p_q) || (on_ng_q && !i_cts && cts_p_q));
    if (fire) begin
      arm_d = 1'b0;
    end
    if (i_cmd_valid && cmd_evt.subcode == sfcu_pkg::SUB_CTS_EVENT) begin
      evn_d = cmd_evt.event_num;
      on_as_d = cmd_evt.on_assert;
      on_ng_d = cmd_evt.on_negate;
      arm_d = cmd_evt.event_num != 16'h0000 &&
        (cmd_evt.on_assert || cmd_evt.on_negate);
      fire = 1'b0;
      if (arm_d && cmd_evt.on_assert != cmd_evt.on_negate &&
          cmd_evt.on_assert == i_cts) begin
        fire = 1'b1;
        arm_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      par_q <= 1'b0;
      cts_p_q <= 1'b0;
      arm_q <= 1'b0;
      on_as_q <= 1'b0;
      on_ng_q <= 1'b0;
      evn_q <= 16'h0000;
      o_rx_accept <= 1'b0;
      o_rx_chunk_len <= 5'h01;
      o_stat_valid <= 1'b0;
      o_stat_word <= 32'h0000_0000;
      o_event_valid <= 1'b0;
      o_event_num <= 16'h0000;
    end else begin
      ovr_q <= ovr_d;
      frm_q <= frm_d;
      par_q <= par_d;
      cts_p_q <= i_cts;
      arm_q <= arm_d;
      on_as_q <= on_as_d;
      on_ng_q <= on_ng_d;
      evn_q <= evn_d;
      o_rx_accept <= !dcd_req_q || i_dcd;
      o_rx_chunk_len <= chunk_for(i_baud_code, fixed_q);
      o_stat_valid <= i_stat_req;
      if (i_stat_req) begin
        o_stat_word <= stat;
      end
      o_event_valid <= fire;
      if (fire) begin
        o_event_num <= evn_d;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_write_taken;
    i_wr_valid && !full && !pend_q;
  endsequence
  property p_mode0_rts;
    (mode_q == sfcu_pkg::MODE_NONE) and s_write_taken |=> o_rts;
  endproperty
  a_mode0_rts: assert property (p_mode0_rts) else $error("rts not raised on write");
  property p_manual_rts;
    mode_q == sfcu_pkg::MODE_MANUAL && !i_rts_cmd_valid |=> o_rts == sw_rts_q;
  endproperty
  a_manual_rts: assert property (p_manual_rts) else $error("manual rts moved");
  property p_rts_cmd_mode;
    mode_q == sfcu_pkg::MODE_NONE && i_rts_cmd_valid && !i_cmd_valid
      |=> mode_q == sfcu_pkg::MODE_MANUAL;
  endproperty
  a_rts_cmd_mode: assert property (p_rts_cmd_mode) else $error("no switch to mode 1");
  property p_cts_gate;
    needs_cts($past(mode_q)) && !$past(i_cts) |-> !o_tx_enable;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("sent without cts");
  property p_stat_answer;
    i_stat_req |=> o_stat_valid && o_stat_word[10:8] == $past(mode_q);
  endproperty
  a_stat_answer: assert property (p_stat_answer) else $error("bad status answer");
  property p_err_sticky;
    i_err_parity ##1 !i_stat_req |=> o_stat_valid || par_q;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("parity flag lost");
  property p_dcd_gate;
    dcd_req_q && !i_dcd |=> !o_rx_accept;
  endproperty
  a_dcd_gate: assert property (p_dcd_gate) else $error("rx open without dcd");
  property p_chunk_fixed;
    fixed_q |=> o_rx_chunk_len == sfcu_pkg::CHUNK_FIXED;
  endproperty
  a_chunk_fixed: assert property (p_chunk_fixed) else $error("chunk not 16");
  sequence s_armed_rise;
    arm_q && on_as_q && !on_ng_q && !i_cts && !i_cmd_valid ##1 i_cts && !i_cmd_valid;
  endsequence
  property p_event_rise;
    s_armed_rise |=> o_event_valid && o_event_num == $past(evn_q);
  endproperty
  a_event_rise: assert property (p_event_rise) else $error("cts rise event missed");
  property p_full_error;
    i_wr_valid && full && !pend_q && !wr_block_q |=> o_wr_error;
  endproperty
  a_full_error: assert property (p_full_error) else $error("full write not refused");
endmodule
`default_nettype wire

// ===== dv/sfcu_modem.sv
// sfcu_modem: far-end modem model on the rts, cts and dcd lines.
// assumes the bench sets the levels just after a rising edge of i_mclk.
`timescale 1ns/1ps
`default_nettype none
module sfcu_modem (
  input wire logic i_mclk,
  input wire logic i_rts,
  input wire logic i_follow,
  input wire logic i_cts_lvl,
  input wire logic i_dcd_lvl,
  output logic o_cts,
  output logic o_dcd
);
  logic [2:0] rts_dly;
  initial begin
    rts_dly = 3'h0;
    o_cts = 1'b0;
    o_dcd = 1'b0;
  end
  // slow answer: cts trails rts by two cycles
  always @(posedge i_mclk) begin
    #2;
    rts_dly = {rts_dly[1:0], i_rts};
    o_cts = i_follow ? rts_dly[2] : i_cts_lvl;
    o_dcd = i_dcd_lvl;
  end
endmodule
`default_nettype wire

// ===== dv/sfcu_core_tb.sv
// sfcu_core_tb: self-checking bench for the serial flow control unit.
// assumes sfcu_pkg, sfcu_core and sfcu_modem are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sfcu_core_tb;
  logic i_mclk, i_reset, i_cmd_valid, i_stat_req, i_rts_cmd_valid, i_rts_cmd_level;
  logic i_wr_valid, i_char_sent, i_char_tick, i_cts, i_dcd, i_rx_near_full, i_rx_drained;
  logic i_err_overrun, i_err_framing, i_err_parity, follow, cts_lvl, dcd_lvl;
  logic o_rts, o_tx_enable, o_tx_demand, o_wr_ack, o_wr_error, o_wr_wait, o_rx_accept;
  logic o_stat_valid, o_event_valid;
  logic [2:0] i_baud_code;
  logic [4:0] o_rx_chunk_len;
  logic [15:0] o_event_num;
  logic [31:0] i_cmd_word, o_stat_word, rnd;
  logic [31:0] stat_q[$];
  logic [15:0] evt_q[$];
  int err_total, cmp_count;

  sfcu_core uut (.i_mclk, .i_reset, .i_cmd_valid, .i_cmd_word, .i_stat_req,
    .i_rts_cmd_valid, .i_rts_cmd_level, .i_wr_valid, .i_char_sent, .i_char_tick,
    .i_cts, .i_dcd, .i_rx_near_full, .i_rx_drained, .i_baud_code, .i_err_overrun,
    .i_err_framing, .i_err_parity, .o_rts, .o_tx_enable, .o_tx_demand, .o_wr_ack,
    .o_wr_error, .o_wr_wait, .o_rx_accept, .o_rx_chunk_len, .o_stat_valid,
    .o_stat_word, .o_event_valid, .o_event_num);
  sfcu_modem modem (.i_mclk, .i_rts(o_rts), .i_follow(follow), .i_cts_lvl(cts_lvl),
    .i_dcd_lvl(dcd_lvl), .o_cts(i_cts), .o_dcd(i_dcd));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_mclk);
    #5;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [31:0] w);
    i_cmd_word = w;
    i_cmd_valid = 1'b1;
    tick();
    i_cmd_valid = 1'b0;
    tick();
  endtask
  task automatic stat(input logic [2:0] md, input logic [15:0] fr, input logic [2:0] fl);
    stat_q.push_back({fr, 5'h0, md, 1'b0, fl, 2'h0, i_dcd, i_cts});
    i_stat_req = 1'b1;
    tick();
    i_stat_req = 1'b0;
    tick();
  endtask
  task automatic wr(input logic dem);
    i_wr_valid = 1'b1;
    tick();
    i_wr_valid = 1'b0;
    cmp("ack", 1'b1, o_wr_ack);
    cmp("demand", dem, o_tx_demand);
    cmp("rts", 1'b1, o_rts);
  endtask
  task automatic rcmd(input logic lv);
    i_rts_cmd_level = lv;
    i_rts_cmd_valid = 1'b1;
    tick();
    i_rts_cmd_valid = 1'b0;
    tick();
  endtask
  // 0 sent, 1 char tick, 2 overrun, 3 framing, 4 parity
  task automatic pulse(input int k);
    {i_char_sent, i_char_tick, i_err_overrun, i_err_framing, i_err_parity} = 5'h10 >> k;
    tick();
    {i_char_sent, i_char_tick, i_err_overrun, i_err_framing, i_err_parity} = 5'h0;
    tick(2);
  endtask
  task automatic ev(input logic [1:0] na, input logic fire);
    rnd = lfsr(rnd);
    if (fire) evt_q.push_back(rnd[15:0] | 16'h1);
    cmd({rnd[15:0] | 16'h1, 3'h0, na, 11'h01a});
  endtask
  task automatic end_sim;
    if (stat_q.size() + evt_q.size() != 0) err_total++;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // result monitor: oldest note against each answer
  always @(posedge i_mclk) begin
    if (o_stat_valid === 1'b1) begin
      if (stat_q.size() == 0) cmp("stat extra", 32'h0, 32'h1);
      else cmp("stat word", stat_q.pop_front(), o_stat_word);
    end
    if (o_event_valid === 1'b1) begin
      if (evt_q.size() == 0) cmp("event extra", 32'h0, 32'h1);
      else cmp("event num", {16'h0, evt_q.pop_front()}, {16'h0, o_event_num});
    end
  end

  initial begin
    repeat (6000) @(posedge i_mclk);
    err_total++;
    end_sim();
  end

  initial begin
    i_reset = 1'b1;
    {i_cmd_valid, i_stat_req, i_rts_cmd_valid, i_rts_cmd_level, i_wr_valid, i_char_sent,
      i_char_tick, i_rx_near_full, i_rx_drained, i_err_overrun, i_err_framing,
      i_err_parity, follow, cts_lvl, dcd_lvl} = '0;
    i_cmd_word = 32'h0;
    i_baud_code = 3'h0;
    rnd = 32'h4ab51939;
    err_total = 0;
    cmp_count = 0;
    tick(5);
    i_reset = 1'b0;
    stat(3'h0, 16'h0100, 3'h0);
    wr(1'b1);
    pulse(0);
    cmp("rts", 1'b0, o_rts);
    rcmd(1'b1);
    stat(3'h1, 16'h0100, 3'h0);
    wr(1'b1);
    pulse(0);
    cmp("rts", 1'b1, o_rts);
    rcmd(1'b0);
    cmp("rts", 1'b0, o_rts);
    cmd(32'h00000823);
    wr(1'b0);
    pulse(0);
    cmd(32'h00000723);
    stat(3'h0, 16'h0100, 3'h0);
    cmd(32'h02000323);
    rcmd(1'b1);
    wr(1'b1);
    rcmd(1'b0);
    cmp("rts", 1'b1, o_rts);
    pulse(0);
    pulse(1);
    cmp("rts", 1'b1, o_rts);
    pulse(1);
    cmp("rts", 1'b0, o_rts);
    cmd(32'h00000423);
    follow = 1'b1;
    wr(1'b1);
    cmp("tx enable", 1'b0, o_tx_enable);
    for (int n = 0; n < 12 && o_tx_enable !== 1'b1; n++) tick();
    cmp("tx enable", 1'b1, o_tx_enable);
    pulse(0);
    cmp("rts", 1'b0, o_rts);
    follow = 1'b0;
    cmd(32'h00000223);
    tick(4);
    i_wr_valid = 1'b1;
    tick(257);
    i_wr_valid = 1'b0;
    cmp("wr error", 1'b1, o_wr_error);
    cmp("tx enable", 1'b0, o_tx_enable);
    stat(3'h2, 16'h0000, 3'h0);
    // blocking write into the full buffer
    cmd(32'h00002223);
    i_wr_valid = 1'b1;
    tick();
    i_wr_valid = 1'b0;
    cmp("wr wait", 1'b1, o_wr_wait);
    cmp("wr error", 1'b0, o_wr_error);
    cts_lvl = 1'b1;
    tick(3);
    cmp("tx enable", 1'b1, o_tx_enable);
    cmp("wr wait", 1'b1, o_wr_wait);
    cts_lvl = 1'b0;
    i_char_sent = 1'b1;
    tick(257);
    i_char_sent = 1'b0;
    cmp("wr wait", 1'b0, o_wr_wait);
    tick(2);
    stat(3'h2, 16'h0100, 3'h0);
    cmd(32'h00000523);
    cmp("rts", 1'b1, o_rts);
    i_rx_near_full = 1'b1;
    tick(2);
    cmp("rts", 1'b0, o_rts);
    {i_rx_near_full, i_rx_drained} = 2'b01;
    tick(2);
    i_rx_drained = 1'b0;
    cmp("rts", 1'b1, o_rts);
    for (int b = 0; b < 5; b++) begin
      i_baud_code = b[2:0];
      tick(2);
      cmp("chunk", 32'h1 << b, {27'h0, o_rx_chunk_len});
    end
    cmd(32'h00001523);
    i_baud_code = 3'h1;
    tick(2);
    cmp("chunk", 32'h10, {27'h0, o_rx_chunk_len});
    cmp("rx accept", 1'b1, o_rx_accept);
    cmd(32'h00000422);
    cmp("rx accept", 1'b0, o_rx_accept);
    dcd_lvl = 1'b1;
    tick(3);
    cmp("rx accept", 1'b1, o_rx_accept);
    pulse(2);
    pulse(4);
    stat(3'h5, 16'h0100, 3'b101);
    pulse(3);
    stat(3'h5, 16'h0100, 3'b010);
    cmd(32'h0000101a);
    ev(2'b10, 1'b1);
    ev(2'b01, 1'b1);
    tick(3);
    cmp("pending", 32'h1, evt_q.size());
    cts_lvl = 1'b1;
    tick(4);
    cmp("pending", 32'h0, evt_q.size());
    // cts already asserted: fires at once
    ev(2'b01, 1'b1);
    tick(3);
    cmp("pending", 32'h0, evt_q.size());
    ev(2'b11, 1'b1);
    tick(3);
    cmp("pending", 32'h1, evt_q.size());
    cts_lvl = 1'b0;
    tick(4);
    cmp("pending", 32'h0, evt_q.size());
    end_sim();
  end
endmodule
`default_nettype wire
